// *** verilog/eqsch_pkg.sv ***
// constants, register map and state type of the egress queue scheduler select
package eqsch_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT2_QUEUE3_SCHED = 8'hb3;
  localparam logic [7:0] PORT2_QUEUE2_SCHED = 8'hb4;
  localparam logic [7:0] PORT2_QUEUE1_SCHED = 8'hb5;
  localparam logic [7:0] PORT2_QUEUE0_SCHED = 8'hb6;
  localparam logic [7:0] PORT3_QUEUE3_SCHED = 8'hb7;
  localparam logic [7:0] PORT3_QUEUE2_SCHED = 8'hb8;
  localparam logic [7:0] PORT3_QUEUE1_SCHED = 8'hb9;
  localparam logic [7:0] PORT3_QUEUE0_SCHED = 8'hba;
  localparam logic [7:0] GLOBAL_CTRL = 8'h05;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int SEL_BIT = 7;
  localparam int CTRL_NO_STRICT_BIT = 3;
  localparam int CTRL_P2_TWO_QUEUE_BIT = 0;
  localparam int CTRL_P3_TWO_QUEUE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic SEL_RESET = 1'b1;
  localparam logic [6:0] WEIGHT_Q3 = 7'h08;
  localparam logic [6:0] WEIGHT_Q2 = 7'h04;
  localparam logic [6:0] WEIGHT_Q1 = 7'h02;
  localparam logic [6:0] WEIGHT_Q0 = 7'h01;
  localparam logic [3:0] FOUR_QUEUE_MASK = 4'hf;
  localparam logic [3:0] TWO_QUEUE_MASK = 4'h3;
  localparam int CREDIT_W = 4;

  typedef struct packed {
    logic [1:0][3:0] sel;
    logic [7:0] ctrl;
    logic [1:0][3:0][CREDIT_W-1:0] credit;
    logic [1:0][3:0] grant;
    logic [1:0] grant_valid;
    logic [31:0] rdata;
    logic err;
  } eqsch_state_t;
endpackage : eqsch_pkg

// *** verilog/eqsch_top.sv ***
// egress queue scheduler select: apb registers and per-port queue picker
//
// Contract
// R1 - all select bits zero gives strict priority
// R2 - strict also needs global bit 3 zero
// R3 - four queues weighted serve 8:4:2:1
// R4 - two queues weighted serve 2:1
// R5 - port 3 has own independent select bits
// R6 - software keeps low seven bits at defaults
// R7 - select bits reset to one, weighted
`timescale 1ns/1ps
module eqsch_top #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] P2_QUEUE_READY,
  input wire logic P2_PICK,
  output logic [3:0] P2_GRANT,
  output logic P2_GRANT_VALID,
  input wire logic [3:0] P3_QUEUE_READY,
  input wire logic P3_PICK,
  output logic [3:0] P3_GRANT,
  output logic P3_GRANT_VALID
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 10 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("ADDR_W must cover the register map");
  end

  // register index width, the word address above the byte lanes
  localparam int IDX_W = ADDR_W - 2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sched_index(input int p, input int q);
    logic [7:0] idx;
    idx = 8'h00;
    unique case ({p[0], q[1:0]})
      3'b011: idx = eqsch_pkg::PORT2_QUEUE3_SCHED;
      3'b010: idx = eqsch_pkg::PORT2_QUEUE2_SCHED;
      3'b001: idx = eqsch_pkg::PORT2_QUEUE1_SCHED;
      3'b000: idx = eqsch_pkg::PORT2_QUEUE0_SCHED;
      3'b111: idx = eqsch_pkg::PORT3_QUEUE3_SCHED;
      3'b110: idx = eqsch_pkg::PORT3_QUEUE2_SCHED;
      3'b101: idx = eqsch_pkg::PORT3_QUEUE1_SCHED;
      3'b100: idx = eqsch_pkg::PORT3_QUEUE0_SCHED;
    endcase
    return idx;
  endfunction : sched_index

  // fixed weights; the low bits are read-only, so they are also the weights
  function automatic logic [6:0] weight(input int q);
    logic [6:0] w;
    w = eqsch_pkg::WEIGHT_Q0;
    unique case (q[1:0])
      2'd3: w = eqsch_pkg::WEIGHT_Q3;
      2'd2: w = eqsch_pkg::WEIGHT_Q2;
      2'd1: w = eqsch_pkg::WEIGHT_Q1;
      2'd0: w = eqsch_pkg::WEIGHT_Q0;
    endcase
    return w;
  endfunction : weight

  // credit loaded at the start of a weighted round
  function automatic logic [eqsch_pkg::CREDIT_W-1:0] full_credit(input int q);
    logic [6:0] w;
    w = weight(q);
    return w[eqsch_pkg::CREDIT_W-1:0];
  endfunction : full_credit

  function automatic logic [3:0] highest(input logic [3:0] v);
    logic [3:0] h;
    h = 4'h0;
    if (v[3])
      h = 4'h8;
    else if (v[2])
      h = 4'h4;
    else if (v[1])
      h = 4'h2;
    else if (v[0])
      h = 4'h1;
    return h;
  endfunction : highest

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eqsch_pkg::eqsch_state_t state;
  eqsch_pkg::eqsch_state_t next_state;

  logic [ADDR_W-3:0] idx;
  logic setup;
  logic access;
  logic [1:0][3:0] ready;
  logic [1:0] pick;
  logic [1:0] two_queue;

  assign idx = PADDR[ADDR_W-1:2];
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign ready[0] = P2_QUEUE_READY;
  assign ready[1] = P3_QUEUE_READY;
  assign pick[0] = P2_PICK;
  assign pick[1] = P3_PICK;
  assign two_queue[0] = state.ctrl[eqsch_pkg::CTRL_P2_TWO_QUEUE_BIT];
  assign two_queue[1] = state.ctrl[eqsch_pkg::CTRL_P3_TWO_QUEUE_BIT];

  always_comb
  begin
    logic hit;
    logic [31:0] rd;
    logic strict;
    logic [3:0] mask;
    logic [3:0] eligible;
    logic [3:0] g;
    logic reload;
    hit = 1'b0;
    rd = 32'h0000_0000;
    strict = 1'b0;
    mask = 4'h0;
    eligible = 4'h0;
    g = 4'h0;
    reload = 1'b0;
    next_state = state;
    next_state.grant_valid = 2'b00;

    // --------------------------------------------------------------
    // apb slave: decode in setup, data and error held for the access
    // --------------------------------------------------------------
    if (idx == IDX_W'(eqsch_pkg::GLOBAL_CTRL))
    begin
      hit = 1'b1;
      rd = {24'h00_0000, state.ctrl};
    end
    for (int p = 0; p < 2; p++)
    begin
      for (int q = 0; q < 4; q++)
      begin
        if (idx == IDX_W'(sched_index(p, q)))
        begin
          hit = 1'b1;
          rd = {24'h00_0000, state.sel[p][q], weight(q)}; // [R6]
        end
      end
    end
    if (PADDR[1:0] != 2'b00)
      hit = 1'b0;
    if (setup)
    begin
      next_state.rdata = (hit && !PWRITE) ? rd : 32'h0000_0000;
      next_state.err = ~hit;
    end
    if (access && PWRITE && PSTRB[0] && !state.err)
    begin
      if (idx == IDX_W'(eqsch_pkg::GLOBAL_CTRL))
        next_state.ctrl = PWDATA[7:0];
      for (int p = 0; p < 2; p++)
      begin
        for (int q = 0; q < 4; q++)
        begin
          // only the select bit is writable; low bits stay fixed
          if (idx == IDX_W'(sched_index(p, q)))
            next_state.sel[p][q] = PWDATA[eqsch_pkg::SEL_BIT]; // [R5] [R6]
        end
      end
    end

    // --------------------------------------------------------------
    // per-port queue picker
    // --------------------------------------------------------------
    for (int p = 0; p < 2; p++)
    begin
      // each port looks only at its own select bits
      strict = (state.sel[p] == 4'h0) && !state.ctrl[eqsch_pkg::CTRL_NO_STRICT_BIT]; // [R1] [R2] [R5]
      mask = two_queue[p] ? eqsch_pkg::TWO_QUEUE_MASK : eqsch_pkg::FOUR_QUEUE_MASK;
      if (pick[p] && (ready[p] & mask) != 4'h0)
      begin
        next_state.grant_valid[p] = 1'b1;
        if (strict)
        begin
          g = highest(ready[p] & mask); // [R2]
        end
        else
        begin
          for (int q = 0; q < 4; q++)
            eligible[q] = ready[p][q] && mask[q] && (state.credit[p][q] != '0);
          reload = (eligible == 4'h0);
          // a round ends when no waiting queue has credit left
          g = reload ? highest(ready[p] & mask) : highest(eligible); // [R3] [R4]
          for (int q = 0; q < 4; q++)
          begin
            if (reload)
              next_state.credit[p][q] = full_credit(q); // [R3] [R4]
            if (g[q])
              next_state.credit[p][q] = reload ?
                full_credit(q) - 1'b1 :
                state.credit[p][q] - 1'b1;
          end
        end
        next_state.grant[p] = g;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state.sel <= {8{eqsch_pkg::SEL_RESET}}; // [R7]
      state.ctrl <= eqsch_pkg::CTRL_RESET;
      state.credit <= '0;
      state.grant <= '0;
      state.grant_valid <= 2'b00;
      state.rdata <= 32'h0000_0000;
      state.err <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA = state.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = access & state.err;
  assign P2_GRANT = state.grant[0];
  assign P2_GRANT_VALID = state.grant_valid[0];
  assign P3_GRANT = state.grant[1];
  assign P3_GRANT_VALID = state.grant_valid[1];

endmodule : eqsch_top

// *** bench/eqsch_checker.sv ***
// assertions on the scheduler select top ports
`timescale 1ns/1ps
module eqsch_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [3:0] P2_QUEUE_READY,
  input wire logic P2_PICK,
  input wire logic [3:0] P2_GRANT,
  input wire logic P2_GRANT_VALID,
  input wire logic [3:0] P3_QUEUE_READY,
  input wire logic P3_PICK,
  input wire logic [3:0] P3_GRANT,
  input wire logic P3_GRANT_VALID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // queues 1 and 0 are eligible in both queue-count modes
  sequence p2_take;
    P2_PICK && (P2_QUEUE_READY & 4'h3) != 4'h0;
  endsequence
  sequence p2_grant;
    P2_GRANT_VALID && $onehot(P2_GRANT);
  endsequence
  p2_answer_a: assert property (p2_take |=> p2_grant)
    else $error("port 2 pick not granted");
  p2_quiet_a: assert property (!P2_PICK |=> !P2_GRANT_VALID)
    else $error("port 2 grant without pick");
  grant_nonempty_a: assert property (P2_GRANT_VALID |->
    (P2_GRANT & ~$past(P2_QUEUE_READY)) == 4'h0)
    else $error("port 2 granted an empty queue");
  grant_hold_a: assert property (!P2_GRANT_VALID |-> $stable(P2_GRANT))
    else $error("port 2 grant moved without a pick");
  p3_answer_a: assert property (P3_PICK && P3_QUEUE_READY[0] |=> P3_GRANT_VALID)
    else $error("port 3 pick not granted");
  p3_quiet_a: assert property (!P3_PICK |=> !P3_GRANT_VALID)
    else $error("port 3 grant without pick");
  p3_nonempty_a: assert property (P3_GRANT_VALID |->
    $onehot(P3_GRANT) && (P3_GRANT & ~$past(P3_QUEUE_READY)) == 4'h0)
    else $error("port 3 granted an empty queue");
  reset_idle_a: assert property ($fell(RESET) |-> !P2_GRANT_VALID && !P3_GRANT_VALID)
    else $error("grant pulse right after reset");
endmodule : eqsch_checker

bind eqsch_top eqsch_checker chk (.*);

// *** bench/test_egress_queue_scheduler_select.sv ***
// self-checking bench of the egress queue scheduler select
`timescale 1ns/1ps
module test_egress_queue_scheduler_select;
  logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0] PSTRB = 4'h1, P2_QUEUE_READY = 4'h0, P3_QUEUE_READY = 4'h0, P2_GRANT, P3_GRANT, r;
  logic PREADY, PSLVERR, P2_PICK = 1'b0, P3_PICK = 1'b0, P2_GRANT_VALID, P3_GRANT_VALID;
  logic [32:0] exp_bus[$];
  logic [3:0] exp_g2[$], exp_g3[$];
  int error_cnt = 0, checks_done = 0, seed = 32'he66a;
  eqsch_top DUT (.*);
  always #20 CLK = ~CLK;
  task cmp_bus(input logic [32:0] e, input logic [32:0] s);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH apb exp %h seen %h", e, s);
    end
  endtask : cmp_bus
  task cmp_grant(input logic [3:0] e, input logic [3:0] s);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH grant exp %h seen %h", e, s);
    end
  endtask : cmp_grant
  // outputs are settled by the falling edge
  always @(negedge CLK)
  begin
    if ((PSEL & PENABLE & PREADY) === 1'b1)
      cmp_bus(exp_bus.pop_front(), {PSLVERR, PRDATA});
    if (P2_GRANT_VALID !== 1'b0)
      cmp_grant(exp_g2.pop_front(), P2_GRANT);
    if (P3_GRANT_VALID !== 1'b0)
      cmp_grant(exp_g3.pop_front(), P3_GRANT);
  end
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [32:0] e);
    exp_bus.push_back(e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {2'h0, idx, 2'h0};
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task readall(input logic s2, input logic s3);
    for (int i = 0; i < 8; i++)
      apb(1'b0, 8'(8'hb3 + i), 8'h0, {25'h0, (i < 4) ? s2 : s3, 7'(7'h08 >> (i % 4))});
  endtask : readall
  task clear2;
    for (int i = 0; i < 4; i++)
      apb(1'b1, 8'(8'hb3 + i), 8'(8'h08 >> i), 33'h0);
  endtask : clear2
  task pick(input logic [3:0] r2, input logic [3:0] r3);
    @(posedge CLK);
    P2_PICK <= 1'b1;
    P3_PICK <= 1'b1;
    P2_QUEUE_READY <= r2;
    P3_QUEUE_READY <= r3;
  endtask : pick
  task idle;
    @(posedge CLK);
    P2_PICK <= 1'b0;
    P3_PICK <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : idle
  function automatic logic [3:0] ratio(input int i, input logic two);
    if (two)
      return (i % 3 == 2) ? 4'h1 : 4'h2;
    return (i < 8) ? 4'h8 : (i < 12) ? 4'h4 : (i < 14) ? 4'h2 : 4'h1;
  endfunction : ratio
  // picks held high back to back; port 3 has queues 1 and 0 busy, all four in two-queue mode
  task run(input int n, input logic two, input logic p3);
    for (int i = 0; i < n; i++)
    begin
      exp_g2.push_back(ratio(i, two));
      if (p3)
        exp_g3.push_back(ratio(i, 1'b1));
      pick(4'hf, p3 ? (two ? 4'hf : 4'h3) : 4'h0);
    end
    idle;
  endtask : run
  task do_reset;
    RESET <= 1'b1;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
  endtask : do_reset
  task end_of_test;
    if (exp_bus.size() + exp_g2.size() + exp_g3.size() != 0)
    begin
      error_cnt++;
      $display("MISMATCH pending exp 0 seen %0d", exp_bus.size() + exp_g2.size() + exp_g3.size());
    end
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #60000;
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    do_reset;
    readall(1'b1, 1'b1);
    apb(1'b0, eqsch_pkg::GLOBAL_CTRL, 8'h0, 33'h0);
    apb(1'b0, 8'hbb, 8'h0, {1'b1, 32'h0});
    $display("test reset values done");
    run(15, 1'b0, 1'b1);
    pick(4'h0, 4'h0);
    idle;
    $display("test weighted ratio done");
    clear2;
    readall(1'b0, 1'b1);
    for (int i = 0; i < 12; i++)
    begin
      r = 4'($random(seed));
      if (r != 4'h0)
        exp_g2.push_back(r[3] ? 4'h8 : r[2] ? 4'h4 : r[1] ? 4'h2 : 4'h1);
      pick(r, 4'h0);
    end
    idle;
    $display("test strict priority done");
    // reset again so the credits start from zero
    do_reset;
    clear2;
    apb(1'b1, eqsch_pkg::GLOBAL_CTRL, 8'h08, 33'h0);
    run(15, 1'b0, 1'b0);
    apb(1'b1, eqsch_pkg::GLOBAL_CTRL, 8'h0b, 33'h0);
    apb(1'b0, eqsch_pkg::GLOBAL_CTRL, 8'h0, {25'h0, 8'h0b});
    run(6, 1'b1, 1'b1);
    $display("test global bit and two queues done");
    end_of_test;
  end
endmodule : test_egress_queue_scheduler_select
